// ===== design/swr_cfg.svh
`ifndef SWR_CFG_SVH
`define SWR_CFG_SVH

// clock rate in MHz
`define SWR_CLK_MHZ      100
// microseconds per millisecond
`define SWR_US_PER_MS    1000
// least reset pulse width in msec
`define SWR_RST_MS       500
// nominal watchdog time-out in msec
`define SWR_WDT_MS       700
// push-button debounce settle time in msec
`define SWR_DEB_MS       10
// counter width, enough for the longest count
`define SWR_CNT_W        27
// stale pin-low samples left in the synchroniser after our own release
`define SWR_SYNC_DEPTH   2

`endif

// ===== design/swr_pkg.sv
`default_nettype none

package swr_pkg;

	// supervisor operating states
	typedef enum logic [1:0] {
		SWR_ST_SUPPLY = 2'h0, // supply low or settling after recovery
		SWR_ST_PULSE  = 2'h1, // timed reset pulse (watchdog or push-button)
		SWR_ST_WATCH  = 2'h2  // pin released, watchdog running
	} swr_state_t;

endpackage : swr_pkg

`default_nettype wire

// ===== design/swr_debounce.sv
`timescale 1ns/1ns
`default_nettype none
`include "swr_cfg.svh"

module swr_debounce import swr_pkg::*; #(
	parameter int CNT_W   = `SWR_CNT_W,
	parameter int DEB_CYC = `SWR_DEB_MS * `SWR_US_PER_MS * `SWR_CLK_MHZ
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// already synchronised level in, settled level out
	input  wire logic level_in,
	output logic      level_r
);

	localparam logic [CNT_W-1:0] DEB_LAST = CNT_W'(DEB_CYC - 1);

	logic [CNT_W-1:0] settle_r; // cycles the input has differed from level_r

	generate
		if (DEB_CYC < 1 || DEB_CYC > 2 ** CNT_W) begin : g_chk
			$error("swr_debounce: DEB_CYC does not fit CNT_W");
		end
	endgenerate

	// settle counter: any bounce back to the held level restarts it
	always_ff @(posedge clk) begin
		if (srst) begin
			settle_r <= '0;
		end else if (level_in == level_r || settle_r == DEB_LAST) begin
			settle_r <= '0;
		end else begin
			settle_r <= settle_r + 1'h1;
		end
	end

	// held level flips only after a full quiet interval
	always_ff @(posedge clk) begin
		if (srst) begin
			level_r <= 1'h0;
		end else if (level_in != level_r && settle_r == DEB_LAST) begin
			level_r <= level_in;
		end
	end

endmodule // swr_debounce
`default_nettype wire

// ===== design/swr_supervisor.sv
`timescale 1ns/1ns
`default_nettype none
`include "swr_cfg.svh"

module swr_supervisor import swr_pkg::*; #(
	parameter int CNT_W   = `SWR_CNT_W,
	parameter int RST_CYC = `SWR_RST_MS * `SWR_US_PER_MS * `SWR_CLK_MHZ,
	parameter int WDT_CYC = `SWR_WDT_MS * `SWR_US_PER_MS * `SWR_CLK_MHZ,
	parameter int DEB_CYC = `SWR_DEB_MS * `SWR_US_PER_MS * `SWR_CLK_MHZ
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// supply comparator, high while supply is in tolerance
	input  wire logic supply_ok_in,
	// pin sensing: below processor reset level, and strobe-level drop
	input  wire logic reset_strobe_pin_low_in,
	input  wire logic reset_strobe_pin_strobe_in,
	// open-drain pin drive
	output logic      reset_strobe_pin_out,
	output logic      reset_strobe_pin_oe
);

	localparam logic [CNT_W-1:0] RST_LAST = CNT_W'(RST_CYC - 1);
	localparam logic [CNT_W-1:0] WDT_LAST = CNT_W'(WDT_CYC - 1);

	// timer counts must fit the counters
	localparam bit CYC_BAD = RST_CYC < 1 || RST_CYC > 2 ** CNT_W ||
		WDT_CYC < 1 || WDT_CYC > 2 ** CNT_W;
	// the debounce must outlast the stale pin-low samples after our own
	// release, else we would see our own pulse as a press, and must settle
	// back inside one pulse, else a held button never re-arms
	localparam bit DEB_BAD = DEB_CYC <= `SWR_SYNC_DEPTH || DEB_CYC >= RST_CYC;

	generate
		if (CYC_BAD || DEB_BAD) begin : g_chk
			$error("swr_supervisor: counts do not suit the timers");
		end
	endgenerate

	logic [1:0]       supply_sync_r;  // supply level synchroniser
	logic [1:0]       low_sync_r;     // pin-low synchroniser
	logic [1:0]       strobe_sync_r;  // strobe synchroniser
	logic             strobe_q_r;     // last strobe level for edge detect
	logic             pushbutton_reset_input_db; // debounced external low
	logic             button_q_r;     // last debounced level
	logic             drive_r;        // registered pin pull-down
	logic [CNT_W-1:0] pulse_cnt_r;    // time spent in a reset pulse
	logic [CNT_W-1:0] wdt_r;          // watchdog time since last strobe
	swr_state_t       state_r;        // current state
	swr_state_t       state_nxt;      // next state

	wire logic supply_ok  = supply_sync_r[1];
	// strobe counts on its rising edge, only while we are not driving
	wire logic strobe_evt = strobe_sync_r[1] & ~strobe_q_r & ~drive_r;
	// a new debounced press; our own pull-down is masked out of the input
	wire logic ext_req    = pushbutton_reset_input_db & ~button_q_r;
	wire logic pulse_done = pulse_cnt_r == RST_LAST;
	wire logic wdt_expire = wdt_r == WDT_LAST;

	// two-flop synchronisers, nothing reads the first stage
	always_ff @(posedge clk) begin
		if (srst) begin
			supply_sync_r <= 2'h0;
			low_sync_r    <= 2'h0;
			strobe_sync_r <= 2'h0;
		end else begin
			supply_sync_r <= {supply_sync_r[0], supply_ok_in};
			low_sync_r    <= {low_sync_r[0], reset_strobe_pin_low_in};
			strobe_sync_r <= {strobe_sync_r[0], reset_strobe_pin_strobe_in};
		end
	end

	// edge history for strobe and button
	always_ff @(posedge clk) begin
		if (srst) begin
			strobe_q_r <= 1'h0;
			button_q_r <= 1'h0;
		end else begin
			strobe_q_r <= strobe_sync_r[1];
			button_q_r <= pushbutton_reset_input_db;
		end
	end

	// contact bounce filter; a held button re-arms a pulse after ours ends
	swr_debounce #(
		.CNT_W   (CNT_W),
		.DEB_CYC (DEB_CYC)
	) u_deb (
		.clk      (clk),
		.srst     (srst),
		.level_in (low_sync_r[1] & ~drive_r),
		.level_r  (pushbutton_reset_input_db)
	);

	// next-state decode; supply loss overrides everything
	always_comb begin
		state_nxt = state_r;
		if (!supply_ok) begin
			state_nxt = SWR_ST_SUPPLY;
		end else begin
			case (state_r)
				SWR_ST_SUPPLY: begin
					if (pulse_done) begin
						state_nxt = SWR_ST_WATCH;
					end
				end
				SWR_ST_PULSE: begin
					if (pulse_done) begin
						state_nxt = SWR_ST_WATCH;
					end
				end
				SWR_ST_WATCH: begin
					if (ext_req) begin
						state_nxt = SWR_ST_PULSE;
					end else if (wdt_expire && !strobe_evt) begin
						state_nxt = SWR_ST_PULSE;
					end
				end
				default: begin
					state_nxt = SWR_ST_SUPPLY;
				end
			endcase
		end
	end

	// state register; reset lands in the supply hold so the pin starts low
	always_ff @(posedge clk) begin
		if (srst) begin
			state_r <= SWR_ST_SUPPLY;
		end else begin
			state_r <= state_nxt;
		end
	end

	// pin drive from a flop, low whenever not watching
	always_ff @(posedge clk) begin
		if (srst) begin
			drive_r <= 1'h1;
		end else begin
			drive_r <= state_nxt != SWR_ST_WATCH;
		end
	end

	// pulse timer: held at zero while supply is low, so the hold
	// only starts once supply is back
	always_ff @(posedge clk) begin
		if (srst || !supply_ok || state_r == SWR_ST_WATCH) begin
			pulse_cnt_r <= '0;
		end else if (!pulse_done) begin
			pulse_cnt_r <= pulse_cnt_r + 1'h1;
		end
	end

	// watchdog timer: cleared by strobes and outside the watch state
	always_ff @(posedge clk) begin
		if (srst || state_r != SWR_ST_WATCH || strobe_evt || wdt_expire) begin
			wdt_r <= '0;
		end else begin
			wdt_r <= wdt_r + 1'h1;
		end
	end

	// open drain: only ever drive a low level
	assign reset_strobe_pin_out = 1'h0;
	assign reset_strobe_pin_oe  = drive_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	supply_low_drive_a: assert property (
		!supply_ok |=> reset_strobe_pin_oe)
		else $error("pin not pulled low with supply low");

	hold_length_a: assert property (
		state_r == SWR_ST_SUPPLY && state_nxt == SWR_ST_WATCH |-> pulse_cnt_r == RST_LAST)
		else $error("supply hold released early");

	strobe_clear_a: assert property (
		state_r == SWR_ST_WATCH && strobe_evt && state_nxt == SWR_ST_WATCH |=> wdt_r == '0)
		else $error("strobe did not restart watchdog");

	timeout_pulse_a: assert property (
		supply_ok && state_r == SWR_ST_WATCH && wdt_expire && !strobe_evt
		|=> state_r == SWR_ST_PULSE ##1 reset_strobe_pin_oe)
		else $error("time-out gave no reset pulse");

	no_early_a: assert property (
		supply_ok && state_r == SWR_ST_WATCH && !wdt_expire && !ext_req
		|=> state_r == SWR_ST_WATCH)
		else $error("reset pulse before time-out");

	pulse_length_a: assert property (
		state_r == SWR_ST_PULSE && state_nxt == SWR_ST_WATCH |-> pulse_cnt_r == RST_LAST)
		else $error("reset pulse too short");

	ext_pulse_a: assert property (
		supply_ok && state_r == SWR_ST_WATCH && ext_req |=> state_r == SWR_ST_PULSE)
		else $error("external request not stretched");

	open_drain_a: assert property (
		reset_strobe_pin_out == 1'h0 && reset_strobe_pin_oe == (state_r != SWR_ST_WATCH))
		else $error("pin drive not open drain low");

	wdt_restart_a: assert property (
		state_r != SWR_ST_WATCH ##1 state_r == SWR_ST_WATCH |-> wdt_r == '0)
		else $error("watchdog not restarted after pulse");

	timeout_c: cover property (state_r == SWR_ST_WATCH && wdt_expire && !strobe_evt);
	strobe_c:  cover property (state_r == SWR_ST_WATCH && strobe_evt);
	button_c:  cover property (state_r == SWR_ST_WATCH && ext_req);
	brown_c:   cover property (state_r == SWR_ST_WATCH && !supply_ok);

endmodule // swr_supervisor
`default_nettype wire

// ===== sim/swr_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module swr_host_model import swr_pkg::*; (
	// requests from the bench acting as host and switch
	input  wire logic strobe_req,
	input  wire logic press,
	// supervisor drive of the shared pin
	input  wire logic oe,
	// sensed pin levels
	output logic      low_in,
	output logic      strobe_in
);
	// wired-or: either party pulling low sinks the pin; a press pulls it low
	assign low_in    = oe | press;
	// divider level shows only while nothing pulls hard low
	assign strobe_in = strobe_req & ~oe & ~press;
endmodule // swr_host_model

`default_nettype wire

// ===== sim/tb_swr_supervisor.sv
`timescale 1ns/1ns
`default_nettype none

module tb_swr_supervisor import swr_pkg::*;;
	// shortened counts keep the run small
	localparam int RC = 20;
	localparam int WC = 40;
	localparam int DC = 4;
	logic clk = 1'h0, srst = 1'h1, sup = 1'h0, str_req = 1'h0, press = 1'h0;
	logic low_in, str_in, pin_out, pin_oe;
	int   mismatches = 0, samples_checked = 0, cyc = 0, hi_cnt = 0, n;

	swr_supervisor #(.RST_CYC(RC), .WDT_CYC(WC), .DEB_CYC(DC)) dut_u (
		.clk(clk), .srst(srst), .supply_ok_in(sup),
		.reset_strobe_pin_low_in(low_in), .reset_strobe_pin_strobe_in(str_in),
		.reset_strobe_pin_out(pin_out), .reset_strobe_pin_oe(pin_oe));
	swr_host_model host_u (.strobe_req(str_req), .press(press), .oe(pin_oe),
		.low_in(low_in), .strobe_in(str_in));

	initial begin
		forever #5 clk = ~clk;
	end

	// counts cycles the pin is pulled
	always @(negedge clk) begin
		if (pin_oe === 1'h1) hi_cnt++;
	end

	// hang guard, well above the whole sequence
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			mismatches++;
			final_report;
		end
	end

	// expected upper bound: sync flops and edge slack
	function automatic int slack(int base);
		return base + 5;
	endfunction

	task automatic final_report;
		if (mismatches == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk_rng(string nm, int lo, int hi, int v);
		samples_checked++;
		if (v < lo || v > hi) begin
			mismatches++;
			$display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, v);
		end
	endtask

	task automatic chk_bit(string nm, logic e, logic v);
		samples_checked++;
		if (v !== e) begin
			mismatches++;
			$display("BAD %s expected %b seen %b", nm, e, v);
		end
	endtask

	// cycles until oe reaches lvl, bounded
	task automatic wait_oe(logic lvl, int lim, output int c);
		c = 0;
		while (pin_oe !== lvl && c < lim) begin
			@(negedge clk);
			c++;
		end
	endtask

	// strobe held 3 cycles, longer than the 2-flop sync needs
	task automatic strobe;
		@(posedge clk) str_req <= 1'h1;
		repeat (3) @(posedge clk);
		str_req <= 1'h0;
	endtask

	initial begin
		n = $urandom(12228);
		repeat (8) @(posedge clk);
		srst <= 1'h0;
		sup  <= 1'h1;
		@(negedge clk);
		chk_bit("oe_at_power", 1'h1, pin_oe);
		wait_oe(1'h0, 200, n);
		chk_rng("power_hold", RC, slack(RC), n);
		repeat (2) begin
			wait_oe(1'h1, 200, n);
			chk_rng("wdt_gap", WC, WC + 2, n);
			wait_oe(1'h0, 200, n);
			chk_rng("wdt_pulse", RC, RC + 1, n);
		end
		// random strobe spacing, always inside one time-out
		hi_cnt = 0;
		repeat (12) begin
			repeat ($urandom_range(5, WC - 12)) @(posedge clk);
			strobe;
		end
		chk_rng("strobed_no_reset", 0, 0, hi_cnt);
		wait_oe(1'h1, 200, n);
		chk_rng("restart_after_strobe", WC, slack(WC), n);
		wait_oe(1'h0, 200, n);
		// supply dip of random length
		@(posedge clk) sup <= 1'h0;
		wait_oe(1'h1, 10, n);
		chk_rng("dip_latency", 0, 4, n);
		repeat ($urandom_range(3, 30)) @(posedge clk);
		sup <= 1'h0;
		@(posedge clk) sup <= 1'h1;
		wait_oe(1'h0, 200, n);
		chk_rng("dip_hold", RC, slack(RC), n);
		// bounce shorter than the settle time is ignored
		hi_cnt = 0;
		@(posedge clk) press <= 1'h1;
		@(posedge clk) press <= 1'h0;
		repeat (25) @(negedge clk);
		chk_rng("bounce_ignored", 0, 0, hi_cnt);
		strobe;
		@(posedge clk) press <= 1'h1;
		wait_oe(1'h1, 40, n);
		chk_rng("press_latency", DC, DC + 6, n);
		@(posedge clk) press <= 1'h0;
		wait_oe(1'h0, 200, n);
		chk_rng("press_pulse", RC - 1, RC + 1, n);
		wait_oe(1'h1, 200, n);
		chk_rng("post_press_gap", WC, WC + 2, n);
		chk_bit("drive_level", 1'h0, pin_out);
		final_report;
	end
endmodule // tb_swr_supervisor

`default_nettype wire
